// ===== hw/walker_pkg.sv
// Package: constants and types for the hashed page table walker
package walker_pkg;

  // ------------------------------------------------------------
  // Register map (APB byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_TABLE_LO  = 12'h004;
  localparam logic [11:0] OFF_TABLE_HI  = 12'h008;
  localparam logic [11:0] OFF_STATUS    = 12'h00C;
  localparam logic [11:0] OFF_FHA_LO    = 12'h010;
  localparam logic [11:0] OFF_FHA_HI    = 12'h014;
  localparam logic [11:0] OFF_HASH_VA_LO = 12'h018;
  localparam logic [11:0] OFF_HASH_VA_HI = 12'h01C;
  localparam logic [11:0] OFF_HASH_LO   = 12'h020;
  localparam logic [11:0] OFF_HASH_HI   = 12'h024;
  localparam logic [11:0] OFF_TAG_LO    = 12'h028;
  localparam logic [11:0] OFF_TAG_HI    = 12'h02C;

  // Control register fields
  localparam int CTRL_WALK_EN = 0;
  localparam int CTRL_FORMAT  = 1;
  localparam int CTRL_BIG_END = 2;
  localparam int CTRL_DATA_TR = 3;
  localparam int CTRL_ABANDON = 4;
  localparam int CTRL_SIZE_LO = 8;
  localparam int CTRL_SIZE_W  = 6;

  // Reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0F00;
  localparam logic [63:0] TABLE_RESET = 64'h0000_0000_0000_0000;

  // Entry layout
  localparam int SHORT_ENTRY_BYTES = 8;
  localparam int LONG_ENTRY_BYTES  = 32;
  localparam int LONG_TAG_OFFSET   = 16;
  localparam int LONG_IGN_OFFSET   = 24;
  localparam int SHORT_SHIFT       = 3;
  localparam int LONG_SHIFT        = 5;
  localparam int TAG_INVALID_POS   = 63;
  localparam int PRESENT_POS       = 0;

  // Outcome kinds reported on the reference return
  typedef enum logic [1:0] {
    RES_RETRY      = 2'b00,
    RES_MISS_FAULT = 2'b01,
    RES_TABLE_FAULT = 2'b10
  } walk_result_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT  = 3'b010,
    ST_CHECK = 3'b011,
    ST_DONE  = 3'b100
  } walk_state_e;

endpackage

// ===== hw/hashed_page_table_walker.sv
// Module: hashed page table walker with APB configuration and TLB interfaces
//
// Summary of operation
// - Walks begin only after a failed TLB lookup and while enabled.
// - Exactly one entry, at the hashed address of the chosen format, is read.
// - A miss on the walker's own table access gives a table translation fault.
// - Short entries without reserved bits are installed, then reference retried.
// - Long entries install only on tag match and no reserved bits.
// - Otherwise a TLB miss fault is raised for the reference.
// - Entries install even when their present bit is clear.
// - The walk may be abandoned while awaiting table words; reference then takes the miss path.
// - Format bit zero selects 8-byte short entries.
// - Short entries need no tag compare; position implies the page.
// - Short installs carry the region identifier of the selected region.
// - Short installs take page size from the region's preferred size.
// - Short installs set protection key equal to the region identifier.
// - Format bit one selects 32-byte long entries with full info.
// - Long tag sits at offset 16; tag invalid set never installs.
// - Generated tags always have the tag invalid bit clear.
// - The long word at offset 24 is ignored by the walker.
// - Faults write the entry's virtual address into fault hash address.
// - The hash readout equals the fault hash address for either format.
// - The tag readout equals the 64-bit tag the walker compares.
// - Data walks need walker enable, region enable and data translation.
// - Non-cacheable tables are never read; every miss faults.
// - Entries are byte-swapped when the big-endian walk bit is set.
`timescale 1ns/1ps
`default_nettype none

module hashed_page_table_walker #(
  parameter int RID_W  = 24,
  parameter int KEY_W  = 24,
  parameter int PGSZ_W = 6
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Failed reference from the TLB
  input  wire logic               miss_valid,
  input  wire logic               miss_is_data,
  input  wire logic [63:0]        miss_va,
  input  wire logic [RID_W-1:0]   region_rid,
  input  wire logic [PGSZ_W-1:0]  region_page_size,
  input  wire logic               region_walk_enable_bit,
  input  wire logic               table_cacheable,
  // Reference outcome
  output logic                    result_valid,
  output walker_pkg::walk_result_e result_kind,
  output logic                    retry_valid,
  output logic [63:0]             retry_va,
  // Table memory reads
  output logic                    mem_req,
  output logic [63:0]             mem_addr,
  output logic [2:0]              mem_words,
  input  wire logic               mem_word_valid,
  input  wire logic [63:0]        mem_word,
  input  wire logic               mem_tlb_miss,
  // TLB install
  output logic                    ins_valid,
  output logic [63:0]             ins_entry,
  output logic [63:0]             ins_va,
  output logic [RID_W-1:0]        ins_rid,
  output logic [PGSZ_W-1:0]       ins_page_size,
  output logic [KEY_W-1:0]        ins_key
);
  import walker_pkg::*;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [63:0] page_table_base_reg_q;
  logic [63:0] fault_hash_address_reg_q;
  logic [63:0] hash_va_q;
  logic        apb_wr;
  logic        apb_rd;

  // Writes land at the access edge; reads are captured at setup so prdata stands with pready
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && !penable && !pwrite;

  wire logic                  table_walker_enable_bit = ctrl_q[CTRL_WALK_EN];
  wire logic                  format_select_bit       = ctrl_q[CTRL_FORMAT];
  wire logic                  big_endian_walk_bit     = ctrl_q[CTRL_BIG_END];
  wire logic                  data_translation_bit    = ctrl_q[CTRL_DATA_TR];
  wire logic                  abandon_walks           = ctrl_q[CTRL_ABANDON];
  wire logic [CTRL_SIZE_W-1:0] table_size             = ctrl_q[CTRL_SIZE_LO +: CTRL_SIZE_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q                <= CTRL_RESET;
      page_table_base_reg_q <= TABLE_RESET;
      hash_va_q             <= TABLE_RESET;
    end else if (apb_wr) begin
      unique case (paddr)
        OFF_CTRL:       ctrl_q <= pwdata;
        OFF_TABLE_LO:   page_table_base_reg_q[31:0] <= pwdata;
        OFF_TABLE_HI:   page_table_base_reg_q[63:32] <= pwdata;
        OFF_HASH_VA_LO: hash_va_q[31:0] <= pwdata;
        OFF_HASH_VA_HI: hash_va_q[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Hash and tag functions
  // ------------------------------------------------------------
  // Long-format hash/tag are implementation specific; simple XOR folds keep them reversible.
  function automatic logic [63:0] entry_addr(input logic [63:0] va, input logic [RID_W-1:0] rid,
                                              input logic [PGSZ_W-1:0] psz, input logic fmt);
    logic [63:0] mask;
    logic [63:0] hpn;
    logic [63:0] offs;
    logic [63:0] rgn;
    mask = (64'h1 << table_size) - 64'h1;
    hpn  = {3'h0, va[60:0]} >> psz;
    if (fmt) begin
      offs = (hpn ^ {{(64-RID_W){1'b0}}, rid}) << LONG_SHIFT;
      rgn  = {page_table_base_reg_q[63:61], 61'h0};
    end else begin
      offs = hpn << SHORT_SHIFT;
      rgn  = {va[63:61], 61'h0};
    end
    entry_addr = rgn | {3'h0, ((page_table_base_reg_q[60:15] & ~mask[60:15]) | (offs[60:15] & mask[60:15])),
                        offs[14:0]};
  endfunction

  function automatic logic [63:0] make_tag(input logic [63:0] va, input logic [RID_W-1:0] rid,
                                            input logic [PGSZ_W-1:0] psz);
    logic [63:0] hpn;
    hpn = {3'h0, va[60:0]} >> psz;
    make_tag = {1'b0, hpn[62:0] ^ {{(63-RID_W){1'b0}}, rid} << 24};
  endfunction

  // Byte reversal of one 64-bit word for big-endian tables
  function automatic logic [63:0] swap64(input logic [63:0] w);
    for (int i = 0; i < 8; i++) begin
      swap64[i*8 +: 8] = w[(7-i)*8 +: 8];
    end
  endfunction

  // Reserved bits of the short entry: bits 51:50 and bit 1, plus reserved attribute codes 1 and 2 in bits 4:2
  function automatic logic has_reserved(input logic [63:0] e);
    has_reserved = (e[51:50] != 2'h0) || e[1] || (e[4:2] == 3'h1) || (e[4:2] == 3'h2);
  endfunction

  // ------------------------------------------------------------
  // Walk state machine
  // ------------------------------------------------------------
  walk_state_e state_q;
  logic [63:0] va_q;
  logic [RID_W-1:0] rid_q;
  logic [PGSZ_W-1:0] psz_q;
  logic        fmt_q;
  logic [63:0] eaddr_q;
  logic [1:0]  word_cnt_q;
  logic [63:0] word0_q;
  logic [63:0] tag_word_q;
  logic        walk_ok;
  logic [63:0] cur_word;

  // Instruction walks need both enables; data walks also need data translation
  assign walk_ok = table_walker_enable_bit && region_walk_enable_bit &&
                   (!miss_is_data || data_translation_bit);
  assign cur_word = big_endian_walk_bit ? swap64(mem_word) : mem_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_IDLE;
      va_q         <= 64'h0;
      rid_q        <= '0;
      psz_q        <= '0;
      fmt_q        <= 1'b0;
      eaddr_q      <= 64'h0;
      word_cnt_q   <= 2'h0;
      word0_q      <= 64'h0;
      tag_word_q   <= 64'h0;
      mem_req      <= 1'b0;
      mem_addr     <= 64'h0;
      mem_words    <= 3'h0;
      result_valid <= 1'b0;
      result_kind  <= RES_RETRY;
      retry_valid  <= 1'b0;
      retry_va     <= 64'h0;
      ins_valid    <= 1'b0;
      ins_entry    <= 64'h0;
      ins_va       <= 64'h0;
      ins_rid      <= '0;
      ins_page_size <= '0;
      ins_key      <= '0;
      fault_hash_address_reg_q <= 64'h0;
    end else begin
      result_valid <= 1'b0;
      retry_valid  <= 1'b0;
      ins_valid    <= 1'b0;
      mem_req      <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (miss_valid) begin
            // Capture now: region inputs may change while the walk runs
            va_q    <= miss_va;
            rid_q   <= region_rid;
            psz_q   <= region_page_size;
            fmt_q   <= format_select_bit;
            eaddr_q <= entry_addr(miss_va, region_rid, region_page_size, format_select_bit);
            if (walk_ok && table_cacheable) begin
              state_q <= ST_FETCH;
            end else begin
              // Disabled or uncached table: straight to the miss path
              fault_hash_address_reg_q <= entry_addr(miss_va, region_rid, region_page_size,
                                                     format_select_bit);
              result_valid <= 1'b1;
              result_kind  <= RES_MISS_FAULT;
            end
          end
        end
        ST_FETCH: begin
          mem_req    <= 1'b1;
          mem_addr   <= eaddr_q;
          // Long entries fetch words 0..2 only; offset 24 is never read
          mem_words  <= fmt_q ? 3'(LONG_TAG_OFFSET / SHORT_ENTRY_BYTES + 1) : 3'h1;
          word_cnt_q <= 2'h0;
          state_q    <= ST_WAIT;
        end
        ST_WAIT: begin
          // Abandon overrides; a late memory answer is simply ignored in idle
          if (abandon_walks) begin
            fault_hash_address_reg_q <= eaddr_q;
            result_valid <= 1'b1;
            result_kind  <= RES_MISS_FAULT;
            state_q      <= ST_IDLE;
          end else if (mem_tlb_miss) begin
            fault_hash_address_reg_q <= eaddr_q;
            result_valid <= 1'b1;
            result_kind  <= RES_TABLE_FAULT;
            state_q      <= ST_IDLE;
          end else if (mem_word_valid) begin
            // Words arrive in order; nothing past the tag word is requested
            word_cnt_q <= word_cnt_q + 2'h1;
            if (word_cnt_q == 2'h0) begin
              word0_q <= cur_word;
            end
            if (word_cnt_q == 2'(LONG_TAG_OFFSET / SHORT_ENTRY_BYTES)) begin
              tag_word_q <= cur_word;
            end
            if (!fmt_q || word_cnt_q == 2'(LONG_TAG_OFFSET / SHORT_ENTRY_BYTES)) begin
              state_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          // Present bit is not checked: not-present entries still install
          if (!has_reserved(word0_q) &&
              (!fmt_q || (!tag_word_q[TAG_INVALID_POS] &&
                          tag_word_q == make_tag(va_q, rid_q, psz_q)))) begin
            ins_valid     <= 1'b1;
            ins_entry     <= word0_q;
            ins_va        <= va_q;
            ins_rid       <= rid_q;
            ins_page_size <= psz_q;
            ins_key       <= KEY_W'(rid_q);
            state_q       <= ST_DONE;
          end else begin
            fault_hash_address_reg_q <= eaddr_q;
            result_valid <= 1'b1;
            result_kind  <= RES_MISS_FAULT;
            state_q      <= ST_IDLE;
          end
        end
        ST_DONE: begin
          // Retry and outcome leave together, one cycle after the install
          retry_valid  <= 1'b1;
          retry_va     <= va_q;
          result_valid <= 1'b1;
          result_kind  <= RES_RETRY;
          state_q      <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB read path
  // ------------------------------------------------------------
  logic [63:0] hash_out;
  logic [63:0] tag_out;
  // Process form so base and size changes seen inside the functions also recompute
  always_comb begin
    hash_out = entry_addr(hash_va_q, region_rid, region_page_size, format_select_bit);
    tag_out  = make_tag(hash_va_q, region_rid, region_page_size);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // One wait-free access: pready rises the cycle after every setup
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_rd) begin
        unique case (paddr)
          OFF_CTRL:       prdata <= ctrl_q;
          OFF_TABLE_LO:   prdata <= page_table_base_reg_q[31:0];
          OFF_TABLE_HI:   prdata <= page_table_base_reg_q[63:32];
          OFF_STATUS:     prdata <= {29'h0, state_q};
          OFF_FHA_LO:     prdata <= fault_hash_address_reg_q[31:0];
          OFF_FHA_HI:     prdata <= fault_hash_address_reg_q[63:32];
          OFF_HASH_VA_LO: prdata <= hash_va_q[31:0];
          OFF_HASH_VA_HI: prdata <= hash_va_q[63:32];
          OFF_HASH_LO:    prdata <= hash_out[31:0];
          OFF_HASH_HI:    prdata <= hash_out[63:32];
          OFF_TAG_LO:     prdata <= tag_out[31:0];
          OFF_TAG_HI:     prdata <= tag_out[63:32];
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// ===== sim/hashed_page_table_walker_checker.sv
// Checker: port-level assertions for the hashed page table walker
`timescale 1ns/1ps
`default_nettype none
module hashed_page_table_walker_checker #(
  parameter int RID_W = 24,
  parameter int KEY_W = 24,
  parameter int PGSZ_W = 6
) (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // Reference side
  input wire logic                    miss_valid,
  input wire logic                    table_cacheable,
  input wire logic                    result_valid,
  input wire walker_pkg::walk_result_e result_kind,
  input wire logic                    retry_valid,
  input wire logic [63:0]             retry_va,
  // Table and TLB side
  input wire logic                    mem_req,
  input wire logic [2:0]              mem_words,
  input wire logic                    mem_tlb_miss,
  input wire logic                    ins_valid,
  input wire logic [63:0]             ins_va,
  input wire logic [RID_W-1:0]        ins_rid,
  input wire logic [KEY_W-1:0]        ins_key
);
  import walker_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_REQ_CAUSE: assert property (mem_req |-> $past(miss_valid, 2) || $past(miss_valid, 3))
    else $error("table read without a failed lookup");
  AST_ONE_ENTRY: assert property (mem_req |=> !mem_req until result_valid)
    else $error("second table read in one walk");
  AST_WALK_BOUND: assert property (mem_req |-> ##[1:40] result_valid)
    else $error("walk never answered");
  AST_WORDS: assert property (mem_req |-> mem_words == 3'h1 || mem_words == 3'h3)
    else $error("bad entry length");
  AST_TABLE_FAULT: assert property (mem_tlb_miss |=> result_valid && result_kind == RES_TABLE_FAULT)
    else $error("table miss without table fault");
  AST_INSTALL_RETRY: assert property (ins_valid |=> retry_valid && result_valid && result_kind == RES_RETRY)
    else $error("install not followed by retry");
  AST_RETRY_CAUSE: assert property (retry_valid |-> $past(ins_valid) && retry_va == $past(ins_va))
    else $error("retry without matching install");
  AST_KEY_RID: assert property (ins_valid |-> ins_key == KEY_W'(ins_rid))
    else $error("key differs from region id");
  AST_PULSE: assert property (result_valid |=> !result_valid)
    else $error("reference answered twice");
  AST_UNCACHED: assert property (miss_valid && !table_cacheable |-> ##[1:2]
    (result_valid && result_kind == RES_MISS_FAULT))
    else $error("uncached table without miss fault");
endmodule
bind hashed_page_table_walker hashed_page_table_walker_checker #(.RID_W(RID_W), .KEY_W(KEY_W), .PGSZ_W(PGSZ_W))
  hashed_page_table_walker_checker_i (.pclk, .presetn, .miss_valid, .table_cacheable, .result_valid,
  .result_kind, .retry_valid, .retry_va, .mem_req, .mem_words, .mem_tlb_miss, .ins_valid, .ins_va,
  .ins_rid, .ins_key);
`default_nettype wire

// ===== sim/table_mem_model.sv
// Partner model: table memory reached through the walker's translation path
`timescale 1ns/1ps
`default_nettype none
module table_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Walker request
  input  wire logic        mem_req,
  input  wire logic [2:0]  mem_words,
  // Scenario controls
  input  wire logic [3:0]  lat,
  input  wire logic        fail,
  input  wire logic [63:0] w0,
  input  wire logic [63:0] tag_w,
  // Answer
  output logic             mem_word_valid,
  output logic [63:0]      mem_word,
  output logic             mem_tlb_miss
);
  logic [63:0] words [3];
  initial begin
    mem_word_valid = 1'b0;
    mem_tlb_miss = 1'b0;
    mem_word = 64'h0;
    forever begin
      @(posedge pclk);
      if (mem_req === 1'b1 && presetn === 1'b1) begin
        words[0] = w0;
        words[1] = ~w0;
        words[2] = tag_w;
        repeat (lat) @(posedge pclk);
        if (fail) begin
          mem_tlb_miss <= 1'b1;
          @(posedge pclk);
          mem_tlb_miss <= 1'b0;
        end else begin
          // Only the requested words; the software word is never served
          for (int i = 0; i < 3 && i < mem_words; i++) begin
            mem_word_valid <= 1'b1;
            mem_word <= words[i];
            @(posedge pclk);
          end
        end
        mem_word_valid <= 1'b0;
        mem_word <= ~words[0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/hashed_page_table_walker_tb_top.sv
// Testbench: directed scenarios for the hashed page table walker
`timescale 1ns/1ps
`default_nettype none
module hashed_page_table_walker_tb_top;
  import walker_pkg::*;
  localparam logic [63:0] VA  = 64'h0000_0000_0000_5000;
  localparam logic [63:0] W0  = 64'h0000_0000_1234_5001;
  localparam logic [23:0] RID = 24'h00ABCD;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         miss_valid, miss_is_data, rwe, cach, result_valid, retry_valid;
  walk_result_e result_kind;
  logic [63:0]  miss_va, retry_va, mem_addr, mem_word, ins_entry, ins_va, w0, tag_w, t64, h64;
  logic [63:0]  g_addr, g_entry, g_rva;
  logic [23:0]  ins_rid, ins_key, g_rid, g_key;
  logic [5:0]   psz, ins_page_size, g_psz;
  logic [2:0]   mem_words, g_words;
  logic         mem_req, mem_word_valid, mem_tlb_miss, ins_valid, fail;
  logic [3:0]   lat;
  int           n_fail, cmp_count, n_req, n_ins, n_rty;

  hashed_page_table_walker hashed_page_table_walker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .miss_valid, .miss_is_data, .miss_va, .region_rid(RID),
    .region_page_size(psz), .region_walk_enable_bit(rwe), .table_cacheable(cach), .result_valid,
    .result_kind, .retry_valid, .retry_va, .mem_req, .mem_addr, .mem_words, .mem_word_valid, .mem_word,
    .mem_tlb_miss, .ins_valid, .ins_entry, .ins_va, .ins_rid, .ins_page_size, .ins_key);
  table_mem_model table_mem_model_i (.pclk, .presetn, .mem_req, .mem_words, .lat, .fail, .w0, .tag_w,
    .mem_word_valid, .mem_word, .mem_tlb_miss);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Pulses are seen at the edge that ends their cycle
  always @(posedge pclk) begin
    if (mem_req === 1'b1) begin
      n_req++;
      g_addr = mem_addr;
      g_words = mem_words;
    end
    if (ins_valid === 1'b1) begin
      n_ins++;
      g_entry = ins_entry;
      g_rid = ins_rid;
      g_psz = ins_page_size;
      g_key = ins_key;
    end
    if (retry_valid === 1'b1) begin
      n_rty++;
      g_rva = retry_va;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd64(input logic [11:0] a, output logic [63:0] v);
    apb(1'b0, a, 32'h0);
    v[31:0] = rd;
    apb(1'b0, 12'(a + 12'h004), 32'h0);
    v[63:32] = rd;
  endtask
  task automatic cfg(input logic fmt, input logic be, input logic ab);
    apb(1'b1, OFF_CTRL, 32'h0000_0F09 | {27'h0, ab, 1'b0, be, fmt, 1'b0});
  endtask
  task automatic walk(input logic isd, input walk_result_e exp);
    {n_req, n_ins, n_rty} = '0;
    @(posedge pclk);
    {miss_valid, miss_is_data} <= {1'b1, isd};
    @(posedge pclk);
    miss_valid <= 1'b0;
    for (int i = 0; i < 60 && result_valid !== 1'b1; i++) @(posedge pclk);
    chk(result_valid, 1'b1);
    chk(result_kind, exp);
    @(posedge pclk);
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_gate();
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({er, rd}, 64'h1_0000_0000);
    walk(1'b0, RES_MISS_FAULT);
    chk(n_req, 0);
    apb(1'b1, OFF_CTRL, 32'h0000_0F01);
    walk(1'b1, RES_MISS_FAULT);
    cfg(1'b0, 1'b0, 1'b0);
    rwe <= 1'b0;
    walk(1'b1, RES_MISS_FAULT);
    {rwe, cach} <= 2'b10;
    walk(1'b0, RES_MISS_FAULT);
    chk(n_req, 0);
    cach <= 1'b1;
  endtask
  task automatic t_short();
    for (int k = 0; k < 2; k++) begin
      w0 <= W0 ^ 64'(k);
      walk(1'b1, RES_RETRY);
      chk(g_addr, 64'h28);
      chk(g_words, 1);
      chk(g_entry, W0 ^ 64'(k));
      chk(g_rid, RID);
      chk(g_psz, 12);
      chk(g_key, RID);
      chk(n_rty, 1);
      chk(g_rva, VA);
    end
    w0 <= W0 | 64'h0008_0000_0000_0000;
    walk(1'b1, RES_MISS_FAULT);
    rd64(OFF_FHA_LO, h64);
    chk(h64, 64'h28);
    apb(1'b1, OFF_HASH_VA_LO, VA[31:0]);
    apb(1'b1, OFF_HASH_VA_HI, VA[63:32]);
    rd64(OFF_HASH_LO, h64);
    chk(h64, 64'h28);
    fail <= 1'b1;
    walk(1'b1, RES_TABLE_FAULT);
    fail <= 1'b0;
  endtask
  task automatic t_long();
    cfg(1'b1, 1'b0, 1'b0);
    lat <= 4'd5;
    rd64(OFF_TAG_LO, t64);
    chk(t64[63], 0);
    {tag_w, w0} <= {t64, W0};
    walk(1'b1, RES_RETRY);
    chk(g_words, 3);
    tag_w <= t64 | 64'h8000_0000_0000_0000;
    walk(1'b1, RES_MISS_FAULT);
    tag_w <= t64 ^ 64'h1;
    walk(1'b1, RES_MISS_FAULT);
    rd64(OFF_FHA_LO, h64);
    rd64(OFF_HASH_LO, t64);
    chk(h64, t64);
  endtask
  task automatic t_misc();
    cfg(1'b0, 1'b1, 1'b0);
    w0 <= W0;
    walk(1'b1, RES_RETRY);
    chk(g_entry, 64'h0150_3412_0000_0000);
    cfg(1'b0, 1'b0, 1'b1);
    lat <= 4'd12;
    walk(1'b1, RES_MISS_FAULT);
    chk(n_ins, 0);
    repeat (20) @(posedge pclk);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, miss_valid, miss_is_data, fail, presetn} = '0;
    {rwe, cach, lat, psz, miss_va, w0, tag_w} = {1'b1, 1'b1, 4'h2, 6'h0C, VA, W0, 64'h0};
    {n_fail, cmp_count} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_gate();
    t_short();
    t_long();
    t_misc();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
